// file: verilog/spcw_pkg.sv
// Shared constants for the serial control port write path
package spcw_pkg;
  // ******************************
  // Link format
  // ******************************
  localparam int ADDR_W = 7;
  localparam logic [6:0] DEV_ADDR = 7'h18;
  localparam logic DIR_WRITE = 1'h0;
  localparam int BYTE_W = 8;
  localparam int TARGET_W = 5;
  localparam int PTR_AUTO_BIT = 7;
  localparam int PTR_TARGET_MSB = 4;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [4:0] BLK1_FIRST = 5'h01;
  localparam logic [4:0] BLK1_LAST = 5'h08;
  localparam logic [4:0] BLK2_FIRST = 5'h09;
  localparam logic [4:0] BLK2_LAST = 5'h11;
  // ******************************
  // Host timing
  // ******************************
  localparam int MCLK_PERIOD_NS = 10;
  localparam int LINK_HALF_NS = 70;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  // ******************************
  // Host command registers
  // ******************************
  localparam logic [4:0] HOST_CTRL_OFS = 5'h00;
  localparam logic [4:0] HOST_PTR_OFS = 5'h04;
  localparam logic [4:0] HOST_DATA_OFS = 5'h08;
  localparam logic [4:0] HOST_STATUS_OFS = 5'h0C;
  localparam logic [4:0] HOST_ADRW_OFS = 5'h10;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_COUNT_LSB = 8;
  localparam logic [7:0] ADRW_RESET = 8'h30;
  localparam logic [7:0] HOST_PTR_RESET = 8'h00;
  localparam logic [31:0] HOST_DATA_RESET = 32'h00000000;
  localparam logic [2:0] HOST_COUNT_RESET = 3'h1;
endpackage

// file: verilog/spcw_link_if.sv
// Three-wire link joining the controller end and the converter end
`timescale 1ns/10ps
interface spcw_link_if;
  logic cs_n;
  logic port_bit_clock;
  logic port_serial_in;
  modport device (
    input cs_n,
    input port_bit_clock,
    input port_serial_in
  );
  modport host (
    output cs_n,
    output port_bit_clock,
    output port_serial_in
  );
endinterface

// file: verilog/spcw_device.sv
// Converter end: serial write port and register pointer
//
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/10ps
module spcw_device (
  input wire logic mclk,
  input wire logic reset_n,
  spcw_link_if.device link,
  output logic reg_wr_strobe,
  output logic [spcw_pkg::TARGET_W-1:0] reg_wr_index,
  output logic [spcw_pkg::BYTE_W-1:0] reg_wr_data,
  output logic [spcw_pkg::BYTE_W-1:0] pointer_value,
  output logic frame_active,
  output logic addr_reject,
  output logic dir_reject
);
  import spcw_pkg::*;

  // ******************************
  // Types and helpers
  // ******************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_PTR = 3'b010,
    ST_DATA = 3'b011,
    ST_IGNORE = 3'b100
  } spcw_dev_state_t;

  // Next target under auto advance, holding at each block end
  function automatic logic [TARGET_W-1:0] advance(input logic [TARGET_W-1:0] t);
    logic [TARGET_W-1:0] r;
    r = t;
    if (t >= BLK1_FIRST && t < BLK1_LAST) begin
      r = t + 5'h01;
    end else if (t >= BLK2_FIRST && t < BLK2_LAST) begin
      r = t + 5'h01;
    end
    return r;
  endfunction

  // ******************************
  // Input synchronisers
  // ******************************
  logic [1:0] cs_sync_reg;
  logic [1:0] clk_sync_reg;
  logic [1:0] din_sync_reg;
  logic clk_prev_reg;
  logic cs_prev_reg;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cs_sync_reg <= 2'h3;
      clk_sync_reg <= 2'h0;
      din_sync_reg <= 2'h0;
    end else begin
      cs_sync_reg <= {cs_sync_reg[0], link.cs_n};
      clk_sync_reg <= {clk_sync_reg[0], link.port_bit_clock};
      din_sync_reg <= {din_sync_reg[0], link.port_serial_in};
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      clk_prev_reg <= 1'h0;
      cs_prev_reg <= 1'h1;
    end else begin
      clk_prev_reg <= clk_sync_reg[1];
      cs_prev_reg <= cs_sync_reg[1];
    end
  end

  logic cs_low;
  logic cs_fall;
  logic bit_rise;
  logic bit_in;
  assign cs_low = !cs_sync_reg[1];
  assign cs_fall = cs_prev_reg && !cs_sync_reg[1];
  assign bit_rise = clk_sync_reg[1] && !clk_prev_reg;
  assign bit_in = din_sync_reg[1];

  // ******************************
  // Bit assembly
  // ******************************
  spcw_dev_state_t state_reg;
  spcw_dev_state_t state_next;
  logic [2:0] bit_cnt_reg;
  logic [BYTE_W-1:0] shift_reg;
  logic [BYTE_W-1:0] byte_word;
  logic byte_done;

  assign byte_word = {shift_reg[BYTE_W-2:0], bit_in};
  assign byte_done = bit_rise && (bit_cnt_reg == 3'h7) &&
                     (state_reg == ST_ADDR || state_reg == ST_PTR || state_reg == ST_DATA);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
    end else if (!cs_low || cs_fall) begin
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
    end else if (bit_rise && state_reg != ST_IGNORE) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_reg <= byte_word;
    end
  end

  // ******************************
  // Frame sequencer
  // ******************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cs_low) begin
          state_next = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (byte_done) begin
          if (byte_word[BYTE_W-1:1] != DEV_ADDR) begin
            state_next = ST_IGNORE;
          end else if (byte_word[0] != DIR_WRITE) begin
            state_next = ST_IGNORE;
          end else begin
            state_next = ST_PTR;
          end
        end
      end
      ST_PTR: begin
        if (byte_done) begin
          state_next = ST_DATA;
        end
      end
      ST_DATA: begin
        state_next = ST_DATA;
      end
      ST_IGNORE: begin
        state_next = ST_IGNORE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (!cs_low) begin
      state_next = ST_IDLE;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ******************************
  // Register pointer
  // ******************************
  logic [BYTE_W-1:0] ptr_reg;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_reg <= PTR_RESET;
    end else if (byte_done && state_reg == ST_PTR) begin
      ptr_reg <= {byte_word[PTR_AUTO_BIT], 2'h0, byte_word[PTR_TARGET_MSB:0]};
    end else if (byte_done && state_reg == ST_DATA && ptr_reg[PTR_AUTO_BIT]) begin
      ptr_reg <= {ptr_reg[7:5], advance(ptr_reg[PTR_TARGET_MSB:0])};
    end
    // Auto advance off leaves the pointer as written
  end

  // ******************************
  // Register write port
  // ******************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_wr_strobe <= 1'h0;
      reg_wr_index <= 5'h00;
      reg_wr_data <= 8'h00;
    end else begin
      reg_wr_strobe <= byte_done && state_reg == ST_DATA;
      if (byte_done && state_reg == ST_DATA) begin
        reg_wr_index <= ptr_reg[PTR_TARGET_MSB:0];
        reg_wr_data <= byte_word;
      end
    end
  end

  // ******************************
  // Status outputs
  // ******************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pointer_value <= PTR_RESET;
      frame_active <= 1'h0;
    end else begin
      pointer_value <= ptr_reg;
      frame_active <= state_reg != ST_IDLE;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      addr_reject <= 1'h0;
      dir_reject <= 1'h0;
    end else begin
      addr_reject <= byte_done && state_reg == ST_ADDR &&
                     byte_word[BYTE_W-1:1] != DEV_ADDR;
      dir_reject <= byte_done && state_reg == ST_ADDR &&
                    byte_word[BYTE_W-1:1] == DEV_ADDR && byte_word[0] != DIR_WRITE;
    end
  end
  // No read data path exists on this port
endmodule

// file: verilog/spcw_host.sv
// Controller end: Avalon-MM commanded serial write master
`timescale 1ns/10ps
module spcw_host (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  spcw_link_if.host link
);
  import spcw_pkg::*;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_LEAD = 3'b001,
    HS_LOW = 3'b010,
    HS_HIGH = 3'b011,
    HS_TRAIL = 3'b100,
    HS_GAP = 3'b101
  } spcw_host_state_t;

  // ******************************
  // Avalon slave
  // ******************************
  logic [7:0] adrw_reg;
  logic [7:0] ptr_byte_reg;
  logic [31:0] data_reg;
  logic [2:0] count_reg;
  logic busy_reg;
  logic accept;
  logic start;
  spcw_host_state_t state_reg;

  assign accept = (avs_read || avs_write) && !avs_waitrequest;
  assign start = accept && avs_write && avs_address == HOST_CTRL_OFS &&
                 avs_writedata[CTRL_START_BIT] && !busy_reg;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'h1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h00000000;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      if (avs_address == HOST_CTRL_OFS) begin
        avs_readdata <= {21'h000000, count_reg, 8'h00};
      end else if (avs_address == HOST_PTR_OFS) begin
        avs_readdata <= {24'h000000, ptr_byte_reg};
      end else if (avs_address == HOST_DATA_OFS) begin
        avs_readdata <= data_reg;
      end else if (avs_address == HOST_STATUS_OFS) begin
        avs_readdata <= {31'h00000000, busy_reg};
      end else if (avs_address == HOST_ADRW_OFS) begin
        avs_readdata <= {24'h000000, adrw_reg};
      end else begin
        avs_readdata <= 32'h00000000;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      adrw_reg <= ADRW_RESET;
      ptr_byte_reg <= HOST_PTR_RESET;
      data_reg <= HOST_DATA_RESET;
      count_reg <= HOST_COUNT_RESET;
    end else if (accept && avs_write && !busy_reg) begin
      if (avs_address == HOST_CTRL_OFS) begin
        count_reg <= avs_writedata[CTRL_COUNT_LSB+2:CTRL_COUNT_LSB];
      end else if (avs_address == HOST_PTR_OFS) begin
        ptr_byte_reg <= avs_writedata[7:0];
      end else if (avs_address == HOST_DATA_OFS) begin
        data_reg <= avs_writedata;
      end else if (avs_address == HOST_ADRW_OFS) begin
        adrw_reg <= avs_writedata[7:0];
      end
    end
  end

  // ******************************
  // Serial engine
  // ******************************
  logic [47:0] shifter_reg;
  logic [5:0] bits_left_reg;
  logic [7:0] timer_reg;
  logic timer_done;
  logic [2:0] nbytes;

  assign timer_done = timer_reg == 8'h00;
  assign nbytes = (avs_writedata[CTRL_COUNT_LSB+2:CTRL_COUNT_LSB] > 3'h4) ? 3'h4 :
                  avs_writedata[CTRL_COUNT_LSB+2:CTRL_COUNT_LSB];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= HS_IDLE;
      busy_reg <= 1'h0;
      timer_reg <= 8'h00;
      bits_left_reg <= 6'h00;
      shifter_reg <= 48'h000000000000;
      link.cs_n <= 1'h1;
      link.port_bit_clock <= 1'h0;
      link.port_serial_in <= 1'h0;
    end else begin
      if (!timer_done) begin
        timer_reg <= timer_reg - 8'h01;
      end
      case (state_reg)
        HS_IDLE: begin
          if (start) begin
            busy_reg <= 1'h1;
            shifter_reg <= {adrw_reg, ptr_byte_reg, data_reg};
            bits_left_reg <= 6'(16 + 8 * int'(nbytes));
            link.cs_n <= 1'h0;
            timer_reg <= 8'(LINK_HALF_CYC - 1);
            state_reg <= HS_LEAD;
          end
        end
        HS_LEAD: begin
          if (timer_done) begin
            link.port_serial_in <= shifter_reg[47];
            timer_reg <= 8'(LINK_HALF_CYC - 1);
            state_reg <= HS_LOW;
          end
        end
        HS_LOW: begin
          if (timer_done) begin
            link.port_bit_clock <= 1'h1;
            timer_reg <= 8'(LINK_HALF_CYC - 1);
            state_reg <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          if (timer_done) begin
            link.port_bit_clock <= 1'h0;
            shifter_reg <= {shifter_reg[46:0], 1'h0};
            link.port_serial_in <= shifter_reg[46];
            bits_left_reg <= bits_left_reg - 6'h01;
            timer_reg <= 8'(LINK_HALF_CYC - 1);
            state_reg <= (bits_left_reg == 6'h01) ? HS_TRAIL : HS_LOW;
          end
        end
        HS_TRAIL: begin
          if (timer_done) begin
            link.cs_n <= 1'h1;
            link.port_serial_in <= 1'h0;
            timer_reg <= 8'(LINK_HALF_CYC - 1);
            state_reg <= HS_GAP;
          end
        end
        HS_GAP: begin
          if (timer_done) begin
            busy_reg <= 1'h0;
            state_reg <= HS_IDLE;
          end
        end
        default: begin
          state_reg <= HS_IDLE;
        end
      endcase
    end
  end
endmodule

// file: dv/spcw_link_assertions.sv
// Concurrent checks on the link and the converter end outputs
`timescale 1ns/10ps
module spcw_link_assertions (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic port_bit_clock,
  input wire logic port_serial_in,
  input wire logic reg_wr_strobe,
  input wire logic [spcw_pkg::TARGET_W-1:0] reg_wr_index,
  input wire logic [spcw_pkg::BYTE_W-1:0] pointer_value,
  input wire logic frame_active,
  input wire logic addr_reject,
  input wire logic dir_reject
);
  import spcw_pkg::*;
  logic rej_reg;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // ********
  // Rejected frame flag
  // ********
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rej_reg <= 1'b0;
    end else if (!frame_active) begin
      rej_reg <= 1'b0;
    end else if (addr_reject || dir_reject) begin
      rej_reg <= 1'b1;
    end
  end
  // ********
  // Checks
  // ********
  resv_zero_a: assert property (pointer_value[6:5] == 2'h0)
    else $error("pointer reserved bits set");
  strobe_frame_a: assert property (reg_wr_strobe |-> frame_active && !rej_reg)
    else $error("write outside accepted frame");
  fixed_ptr_a: assert property (reg_wr_strobe && !pointer_value[7] |->
    reg_wr_index == pointer_value[4:0])
    else $error("write index differs from fixed pointer");
  adv_step_a: assert property (reg_wr_strobe && pointer_value[7] |-> ##[0:3]
    pointer_value[4:0] == ((reg_wr_index inside {[5'h01:5'h07], [5'h09:5'h10]}) ?
    reg_wr_index + 5'h01 : reg_wr_index))
    else $error("pointer advanced wrongly");
  strobe_gap_a: assert property (reg_wr_strobe |=> !reg_wr_strobe [*8])
    else $error("writes too close");
  idle_quiet_a: assert property (cs_n [*8] |-> !reg_wr_strobe)
    else $error("write with select high");
  frame_end_a: assert property ($rose(cs_n) |-> ##[1:6] !frame_active)
    else $error("frame not closed");
  frame_start_a: assert property ($fell(cs_n) |-> ##[1:6] frame_active)
    else $error("frame not opened");
  reject_once_a: assert property (addr_reject || dir_reject |=>
    !addr_reject && !dir_reject)
    else $error("reject pulse too long");
  clk_idle_a: assert property (cs_n |-> !port_bit_clock)
    else $error("bit clock high with select high");
  data_hold_a: assert property (port_bit_clock && $past(port_bit_clock) |->
    $stable(port_serial_in))
    else $error("serial data moved while clock high");
endmodule

// file: dv/tb_spi_control_port_write.sv
// Testbench joining both ends of the serial control port
`timescale 1ns/10ps
module tb_spi_control_port_write;
  import spcw_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic reg_wr_strobe;
  logic [TARGET_W-1:0] reg_wr_index;
  logic [BYTE_W-1:0] reg_wr_data;
  logic [BYTE_W-1:0] pointer_value;
  logic frame_active;
  logic addr_reject;
  logic dir_reject;
  logic [7:0] ep = 8'h00;
  logic wq[$];
  logic [4:0] iq[$];
  logic [7:0] dq[$];
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  int ra = 0;
  int rd = 0;
  always #5 mclk = ~mclk;
  spcw_link_if u_spcw_link_if();
  spcw_host u_spcw_host (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(u_spcw_link_if));
  spcw_device u_spcw_device (.mclk(mclk), .reset_n(reset_n), .link(u_spcw_link_if),
    .reg_wr_strobe(reg_wr_strobe), .reg_wr_index(reg_wr_index), .reg_wr_data(reg_wr_data),
    .pointer_value(pointer_value), .frame_active(frame_active),
    .addr_reject(addr_reject), .dir_reject(dir_reject));
  spcw_link_assertions u_spcw_link_assertions (.mclk(mclk), .reset_n(reset_n),
    .cs_n(u_spcw_link_if.cs_n), .port_bit_clock(u_spcw_link_if.port_bit_clock),
    .port_serial_in(u_spcw_link_if.port_serial_in), .reg_wr_strobe(reg_wr_strobe),
    .reg_wr_index(reg_wr_index), .pointer_value(pointer_value),
    .frame_active(frame_active), .addr_reject(addr_reject), .dir_reject(dir_reject));
  // ********
  // Monitors and timeout
  // ********
  always @(posedge u_spcw_link_if.port_bit_clock) begin
    if (u_spcw_link_if.cs_n === 1'b0) begin
      wq.push_back(u_spcw_link_if.port_serial_in);
    end
  end
  always @(posedge mclk) begin
    if (reg_wr_strobe === 1'b1) begin
      iq.push_back(reg_wr_index);
      dq.push_back(reg_wr_data);
    end
    ra += (addr_reject === 1'b1);
    rd += (dir_reject === 1'b1);
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      $display("FAIL %0t timeout", $time);
      stop_test();
    end
  end
  // ********
  // Tasks
  // ********
  task stop_test;
    $display("Checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask
  task bus(input logic [4:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task rdc(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 32'h00000000, q);
    chk(q, e);
  endtask
  function automatic logic [7:0] wbyte(input int s);
    for (int i = 0; i < 8; i++) wbyte[7-i] = wq[s+i];
  endfunction
  function automatic logic [4:0] nxt(input logic [4:0] i, input logic en);
    nxt = (en && (i inside {[5'h01:5'h07], [5'h09:5'h10]})) ? i + 5'h01 : i;
  endfunction
  task frame(input logic [7:0] aw, input logic [7:0] p, input logic [31:0] d,
    input logic [2:0] n);
    logic [31:0] q;
    logic [4:0] ix;
    logic ok;
    int ne;
    wq.delete();
    iq.delete();
    dq.delete();
    ra = 0;
    rd = 0;
    ok = (aw[7:1] === DEV_ADDR) && (aw[0] === DIR_WRITE);
    ne = (n > 3'h4) ? 4 : n;
    bus(HOST_ADRW_OFS, 1'b1, {24'h000000, aw}, q);
    bus(HOST_PTR_OFS, 1'b1, {24'h000000, p}, q);
    bus(HOST_DATA_OFS, 1'b1, d, q);
    bus(HOST_CTRL_OFS, 1'b1, {21'h000000, n, 8'h01}, q);
    do bus(HOST_STATUS_OFS, 1'b0, 32'h00000000, q); while (q[0] !== 1'b0);
    repeat (8) @(posedge mclk);
    chk(wq.size(), 8 * (2 + ne));
    chk(wbyte(0), aw);
    chk(wbyte(8), p);
    chk(iq.size(), ok ? ne : 0);
    if (ok) ep = {p[7], 2'b00, p[4:0]};
    ix = ep[4:0];
    for (int k = 0; k < iq.size(); k++) begin
      chk(iq[k], ix);
      chk(dq[k], d[31-8*k -: 8]);
      ix = nxt(ix, ep[7]);
    end
    ep[4:0] = ix;
    chk(pointer_value, ep);
    chk(ra, !ok && aw[7:1] !== DEV_ADDR);
    chk(rd, !ok && aw[7:1] === DEV_ADDR);
    chk(frame_active, 1'b0);
  endtask
  // ********
  // Scenarios
  // ********
  task t_reset;
    chk(pointer_value, PTR_RESET);
    chk(u_spcw_link_if.cs_n, 1'b1);
    rdc(HOST_CTRL_OFS, {21'h000000, HOST_COUNT_RESET, 8'h00});
    rdc(HOST_ADRW_OFS, ADRW_RESET);
    rdc(HOST_PTR_OFS, HOST_PTR_RESET);
    rdc(HOST_DATA_OFS, HOST_DATA_RESET);
    rdc(5'h14, 32'h00000000);
  endtask
  task t_single;
    frame(8'h30, 8'h03, 32'hA5000000, 3'h1);
  endtask
  task t_hold;
    frame(8'h30, 8'h05, 32'h11220000, 3'h2);
  endtask
  task t_zero;
    frame(8'h30, 8'h0A, 32'h00000000, 3'h0);
  endtask
  task t_blk1;
    frame(8'h30, 8'hE6, 32'h5A6B7C8D, 3'h4);
  endtask
  task t_blk2;
    frame(8'h30, 8'h8F, 32'hC3D4E5F6, 3'h5);
  endtask
  task t_reject;
    frame(8'h32, 8'h01, 32'hFF000000, 3'h1);
    frame(8'hB0, 8'h02, 32'hEE000000, 3'h1);
    frame(8'h31, 8'h03, 32'hDD000000, 3'h1);
  endtask
  task t_rearm;
    frame(8'h30, 8'h00, 32'h77000000, 3'h1);
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset();
    t_single();
    t_hold();
    t_zero();
    t_blk1();
    t_blk2();
    t_reject();
    t_rearm();
    stop_test();
  end
endmodule
